// [src/tascp_pkg.sv]
package tascp_pkg;

    // ****************************************************
    // Control byte layout
    // ****************************************************
    localparam int CMD_W = 8;
    localparam int BIT_START = 7;
    localparam int BIT_CH_HI = 6;
    localparam int BIT_CH_LO = 4;
    localparam int BIT_MODE = 3;
    localparam int BIT_REFSEL = 2;
    localparam int BIT_PD_HI = 1;
    localparam int BIT_PD_LO = 0;
    localparam int BIT_PULLUP = 3;
    localparam int BIT_BYPASS = 2;
    localparam int BIT_TIMING = 1;
    localparam int BIT_SWRST = 0;

    // ****************************************************
    // Channel codes
    // ****************************************************
    localparam logic [2:0] CH_TEMP_A = 3'h0;
    localparam logic [2:0] CH_Y = 3'h1;
    localparam logic [2:0] CH_SETUP = 3'h2;
    localparam logic [2:0] CH_PRESS_A = 3'h3;
    localparam logic [2:0] CH_PRESS_B = 3'h4;
    localparam logic [2:0] CH_X = 3'h5;
    localparam logic [2:0] CH_AUX = 3'h6;
    localparam logic [2:0] CH_TEMP_B = 3'h7;

    // ****************************************************
    // Types
    // ****************************************************
    typedef struct packed {
        logic pullup_90k;
        logic median_average_filter_bypass;
        logic early_msb;
    } tascp_setup_s;

    typedef struct packed {
        logic [2:0] chan;
        logic res_8bit;
        logic reference_select;
        logic power_down_sel_hi;
        logic power_down_sel_lo;
    } tascp_meas_s;

    typedef struct packed {
        logic xp;
        logic xn;
        logic yp;
        logic yn;
    } tascp_drv_s;

    typedef enum logic {ST_IDLE, ST_CONV} tascp_state_e;

    // ****************************************************
    // Reset values
    // ****************************************************
    localparam tascp_setup_s SETUP_RST = 3'h0;
    localparam tascp_meas_s MEAS_RST = 7'h00;
    localparam logic [3:0] SYNC_RST = 4'h2;

    // ****************************************************
    // Timing
    // ****************************************************
    localparam int REF_CLK_NS = 50;
    localparam int CONV_CLK12_NS = 500;
    localparam int CONV_CLK8_NS = 250;
    localparam logic [3:0] DIV_12 = 4'(CONV_CLK12_NS / REF_CLK_NS);
    localparam logic [3:0] DIV_8 = 4'(CONV_CLK8_NS / REF_CLK_NS);
    localparam logic [3:0] TICKS_12 = 4'hD;
    localparam logic [3:0] TICKS_8 = 4'h9;
    localparam logic [2:0] FILTER_SAMPLES = 3'h7;
    localparam logic [3:0] RES_BITS_12 = 4'hC;
    localparam logic [3:0] RES_BITS_8 = 4'h8;

endpackage

// [src/tascp_command_port.sv]
`timescale 1ns/1ps
module tascp_command_port (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso_o,
    output logic miso_oe_n,
    input wire logic panel_touched,
    input wire logic [11:0] adc_result,
    output logic pen_touch_irq_n,
    output logic [2:0] chan_sel,
    output logic adc_res_8bit,
    output logic adc_powered,
    output logic ref_ratiometric,
    output tascp_pkg::tascp_drv_s drv,
    output logic pullup_90k,
    output logic median_average_filter_bypass,
    output logic conv_busy,
    output logic result_valid,
    output logic conv_invalid
);

    // ****************************************************
    // Decode functions
    // ****************************************************
    // Driver switches for a channel code
    function automatic tascp_pkg::tascp_drv_s chan_drv(input logic [2:0] ch);
        tascp_pkg::tascp_drv_s d;
        d = 4'h0;
        case (ch)
            tascp_pkg::CH_Y: begin
                d.yp = 1'b1;
                d.yn = 1'b1;
            end
            tascp_pkg::CH_X: begin
                d.xp = 1'b1;
                d.xn = 1'b1;
            end
            tascp_pkg::CH_PRESS_A, tascp_pkg::CH_PRESS_B: begin
                d.xn = 1'b1;
                d.yp = 1'b1;
            end
            default: d = 4'h0;
        endcase
        return d;
    endfunction

    // Touch-panel channels may use plate references
    function automatic logic touch_chan(input logic [2:0] ch);
        return (ch == tascp_pkg::CH_X) || (ch == tascp_pkg::CH_Y) ||
               (ch == tascp_pkg::CH_PRESS_A) || (ch == tascp_pkg::CH_PRESS_B);
    endfunction

    // ****************************************************
    // Pin synchronisers and edge detect
    // ****************************************************
    logic [3:0] sync1_r, sync2_r;
    logic sclk_d_r, cs_d_r;
    logic sclk_s, cs_s, mosi_s, touch_s;
    logic sclk_rise, sclk_fall, cs_rise, byte_done;
    // Two flops per pin, then one more stage for edges
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= tascp_pkg::SYNC_RST;
            sync2_r <= tascp_pkg::SYNC_RST;
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end else begin
            sync1_r <= {panel_touched, mosi, cs_n, sclk};
            sync2_r <= sync1_r;
            sclk_d_r <= sclk_s;
            cs_d_r <= cs_s;
        end
    end

    assign sclk_s = sync2_r[0];
    assign cs_s = sync2_r[1];
    assign mosi_s = sync2_r[2];
    assign touch_s = sync2_r[3];
    // Idle-low clock: rising edge samples, falling edge shifts
    assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_s;
    assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_s;
    assign cs_rise = cs_s & ~cs_d_r;

    // ****************************************************
    // Command receiver
    // ****************************************************
    logic [6:0] rx_sh_r, rx_sh_nxt;
    logic [2:0] rx_cnt_r, rx_cnt_nxt;
    logic [7:0] cmd;
    // Shift in MSB first; counter wraps so bytes run back to back
    always_comb begin
        rx_sh_nxt = rx_sh_r;
        rx_cnt_nxt = rx_cnt_r;
        if (cs_s) begin
            rx_cnt_nxt = 3'h0;
        end else if (sclk_rise) begin
            rx_sh_nxt = {rx_sh_r[5:0], mosi_s};
            rx_cnt_nxt = rx_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sh_r <= 7'h00;
            rx_cnt_r <= 3'h0;
        end else begin
            rx_sh_r <= rx_sh_nxt;
            rx_cnt_r <= rx_cnt_nxt;
        end
    end

    assign byte_done = sclk_rise && (rx_cnt_r == 3'h7);
    assign cmd = {rx_sh_r, mosi_s};

    // ****************************************************
    // Command decode, conversion and read-out
    // ****************************************************
    tascp_pkg::tascp_state_e state_r, state_nxt;
    tascp_pkg::tascp_setup_s setup_r, setup_nxt;
    tascp_pkg::tascp_meas_s meas_r, meas_nxt;
    tascp_pkg::tascp_drv_s drv_r, drv_nxt;
    logic [3:0] div_r, div_nxt, tick_r, tick_nxt, div_end, tick_end;
    logic [2:0] samp_r, samp_nxt, samp_end;
    logic [12:0] tx_sh_r, tx_sh_nxt;
    logic [3:0] tx_left_r, tx_left_nxt, res_bits;
    logic valid_r, valid_nxt, invalid_r, invalid_nxt, irq_n_r, irq_n_nxt;
    logic powered_r, powered_nxt, ratio_r, ratio_nxt, is_valid_cmd, is_setup;
    logic [11:0] res_word;
    // Valid command only with start flag one
    assign is_valid_cmd = byte_done && cmd[tascp_pkg::BIT_START];
    assign is_setup = cmd[tascp_pkg::BIT_CH_HI:tascp_pkg::BIT_CH_LO] ==
                      tascp_pkg::CH_SETUP;
    // Conversion clock speed and length follow resolution and filter
    assign div_end = meas_r.res_8bit ? tascp_pkg::DIV_8 - 4'h1
                                     : tascp_pkg::DIV_12 - 4'h1;
    assign tick_end = meas_r.res_8bit ? tascp_pkg::TICKS_8 - 4'h1
                                      : tascp_pkg::TICKS_12 - 4'h1;
    assign samp_end = setup_r.median_average_filter_bypass ? 3'h0
                    : tascp_pkg::FILTER_SAMPLES - 3'h1;
    assign res_word = meas_r.res_8bit ? {adc_result[11:4], 4'h0}
                                      : adc_result;
    assign res_bits = meas_r.res_8bit ? tascp_pkg::RES_BITS_8
                                      : tascp_pkg::RES_BITS_12;

    // Next-state logic for the command engine
    always_comb begin
        state_nxt = state_r;
        setup_nxt = setup_r;
        meas_nxt = meas_r;
        div_nxt = div_r;
        tick_nxt = tick_r;
        samp_nxt = samp_r;
        tx_sh_nxt = tx_sh_r;
        tx_left_nxt = tx_left_r;
        valid_nxt = valid_r;
        invalid_nxt = invalid_r;
        // Result shifts on falling edges alongside the incoming byte
        if (sclk_fall && tx_left_r != 4'h0) begin
            tx_sh_nxt = {tx_sh_r[11:0], 1'b0};
            tx_left_nxt = tx_left_r - 4'h1;
        end
        // Releasing select mid read-out drops the remaining bits
        if (cs_rise && tx_left_r != 4'h0) begin
            tx_sh_nxt = 13'h0000;
            tx_left_nxt = 4'h0;
        end
        case (state_r)
            tascp_pkg::ST_CONV: begin
                if (div_r != div_end) begin
                    div_nxt = div_r + 4'h1;
                end else begin
                    div_nxt = 4'h0;
                    if (tick_r != tick_end) begin
                        tick_nxt = tick_r + 4'h1;
                    end else begin
                        tick_nxt = 4'h0;
                        if (samp_r != samp_end) begin
                            samp_nxt = samp_r + 3'h1;
                        end else begin
                            state_nxt = tascp_pkg::ST_IDLE;
                            valid_nxt = 1'b1;
                            if (setup_r.early_msb) begin
                                tx_sh_nxt = {res_word, 1'b0};
                                tx_left_nxt = res_bits;
                            end else begin
                                tx_sh_nxt = {1'b0, res_word};
                                tx_left_nxt = res_bits + 4'h1;
                            end
                        end
                    end
                end
                // Clock activity before completion ends it as bad
                if (sclk_rise) begin
                    state_nxt = tascp_pkg::ST_IDLE;
                    invalid_nxt = 1'b1;
                    valid_nxt = 1'b0;
                end
            end
            tascp_pkg::ST_IDLE: state_nxt = tascp_pkg::ST_IDLE;
            default: state_nxt = tascp_pkg::ST_IDLE;
        endcase
        // A valid command wins over anything above
        if (is_valid_cmd) begin
            if (is_setup) begin
                setup_nxt.pullup_90k = cmd[tascp_pkg::BIT_PULLUP];
                setup_nxt.median_average_filter_bypass =
                    cmd[tascp_pkg::BIT_BYPASS];
                setup_nxt.early_msb = cmd[tascp_pkg::BIT_TIMING];
                if (cmd[tascp_pkg::BIT_SWRST]) begin
                    state_nxt = tascp_pkg::ST_IDLE;
                    setup_nxt = tascp_pkg::SETUP_RST;
                    meas_nxt = tascp_pkg::MEAS_RST;
                    tx_sh_nxt = 13'h0000;
                    tx_left_nxt = 4'h0;
                    valid_nxt = 1'b0;
                    invalid_nxt = 1'b0;
                end
            end else begin
                // Restart aborts any conversion still running
                meas_nxt = cmd[6:0];
                state_nxt = tascp_pkg::ST_CONV;
                div_nxt = 4'h0;
                tick_nxt = 4'h0;
                samp_nxt = 3'h0;
                valid_nxt = 1'b0;
                invalid_nxt = 1'b0;
            end
        end
    end

    // Pen interrupt, power and analog routing from state
    always_comb begin
        irq_n_nxt = 1'b1;
        powered_nxt = meas_r.power_down_sel_lo;
        drv_nxt = 4'h0;
        ratio_nxt = 1'b0;
        if (state_nxt == tascp_pkg::ST_CONV) begin
            irq_n_nxt = 1'b0;
            powered_nxt = 1'b1;
        end else if (!meas_nxt.power_down_sel_lo && touch_s) begin
            irq_n_nxt = 1'b0;
        end
        if (state_nxt == tascp_pkg::ST_CONV ||
            meas_nxt.power_down_sel_lo) begin
            drv_nxt = chan_drv(meas_nxt.chan);
            ratio_nxt = !meas_nxt.reference_select &&
                        touch_chan(meas_nxt.chan);
        end else begin
            drv_nxt.yn = 1'b1; // Y- grounds panel for touch sense
        end
        if (meas_nxt.power_down_sel_hi && !meas_nxt.power_down_sel_lo &&
            state_nxt != tascp_pkg::ST_CONV) begin
            powered_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= tascp_pkg::ST_IDLE;
            setup_r <= tascp_pkg::SETUP_RST;
            meas_r <= tascp_pkg::MEAS_RST;
            div_r <= 4'h0;
            tick_r <= 4'h0;
            samp_r <= 3'h0;
            tx_sh_r <= 13'h0000;
            tx_left_r <= 4'h0;
            valid_r <= 1'b0;
            invalid_r <= 1'b0;
            irq_n_r <= 1'b1;
            powered_r <= 1'b0;
            ratio_r <= 1'b0;
            drv_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            setup_r <= setup_nxt;
            meas_r <= meas_nxt;
            div_r <= div_nxt;
            tick_r <= tick_nxt;
            samp_r <= samp_nxt;
            tx_sh_r <= tx_sh_nxt;
            tx_left_r <= tx_left_nxt;
            valid_r <= valid_nxt;
            invalid_r <= invalid_nxt;
            irq_n_r <= irq_n_nxt;
            powered_r <= powered_nxt;
            ratio_r <= ratio_nxt;
            drv_r <= drv_nxt;
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    assign miso_o = tx_sh_r[12];
    assign miso_oe_n = cs_s;
    assign pen_touch_irq_n = irq_n_r;
    assign chan_sel = meas_r.chan;
    assign adc_res_8bit = meas_r.res_8bit;
    assign adc_powered = powered_r;
    assign ref_ratiometric = ratio_r;
    assign drv = drv_r;
    assign pullup_90k = setup_r.pullup_90k;
    assign median_average_filter_bypass = setup_r.median_average_filter_bypass;
    assign conv_busy = (state_r == tascp_pkg::ST_CONV);
    assign result_valid = valid_r;
    assign conv_invalid = invalid_r;

endmodule

// [verification/tascp_command_port_chk.sv]
`timescale 1ns/1ps
// ****
// Port checker
// ****
module tascp_command_port_chk (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic miso_oe_n,
    input wire logic pen_touch_irq_n,
    input wire logic [2:0] chan_sel,
    input wire logic adc_powered,
    input wire logic ref_ratiometric,
    input wire tascp_pkg::tascp_drv_s drv,
    input wire logic pullup_90k,
    input wire logic median_average_filter_bypass,
    input wire logic conv_busy,
    input wire logic result_valid,
    input wire logic conv_invalid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [3:0] drv_exp;

    // Driver pattern implied by the channel
    always_comb begin
        case (chan_sel)
            3'h1: drv_exp = 4'h3;
            3'h5: drv_exp = 4'hC;
            3'h3, 3'h4: drv_exp = 4'h6;
            default: drv_exp = 4'h0;
        endcase
    end

    a_busy_irq_low: assert property (conv_busy |-> !pen_touch_irq_n)
        else $error("pen interrupt high while converting");
    a_end_flagged: assert property ($fell(conv_busy) |->
        ##[0:1] (result_valid || conv_invalid))
        else $error("conversion ended without a status flag");
    a_sclk_abort: assert property (conv_busy && !cs_n && $rose(sclk) |->
        ##[1:6] conv_invalid)
        else $error("clock edge did not cut conversion short");
    a_oe_select: assert property ((!cs_n)[*5] |=> !miso_oe_n)
        else $error("output not driven while selected");
    a_oe_release: assert property (cs_n[*5] |=> miso_oe_n)
        else $error("output still driven after release");
    a_setup_kept: assert property ($rose(conv_busy) |->
        $stable(pullup_90k) && $stable(median_average_filter_bypass))
        else $error("measurement changed setup bits");
    a_ratio_chan: assert property (ref_ratiometric |->
        chan_sel inside {3'h1, 3'h3, 3'h4, 3'h5})
        else $error("plate reference on a single-ended channel");
    a_drv_chan: assert property (conv_busy && $past(conv_busy) |->
        drv == drv_exp)
        else $error("driver switches do not match channel");
    a_busy_min: assert property ($rose(conv_busy) |-> conv_busy[*8])
        else $error("conversion stopped without cause");
    a_powered_conv: assert property (conv_busy && $past(conv_busy) |->
        adc_powered)
        else $error("converter off during conversion");
endmodule

bind tascp_command_port tascp_command_port_chk u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .miso_oe_n(miso_oe_n), .pen_touch_irq_n(pen_touch_irq_n),
    .chan_sel(chan_sel), .adc_powered(adc_powered),
    .ref_ratiometric(ref_ratiometric), .drv(drv), .pullup_90k(pullup_90k),
    .median_average_filter_bypass(median_average_filter_bypass),
    .conv_busy(conv_busy), .result_valid(result_valid),
    .conv_invalid(conv_invalid)
);

// [verification/tascp_host.sv]
`timescale 1ns/1ps
// ****
// Host master, clock polarity and phase zero
// ****
module tascp_host (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe_n
);
    localparam int HALF = 200;
    logic last_bit;

    // Idle: clock low, select high
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        last_bit = 1'b0;
    end

    // One byte each way, MSB first
    task automatic xfer(input logic [7:0] tx, input bit hold,
                        output logic [7:0] rx);
        cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i]; // Half a clock before the rise
            #HALF;
            rx[i] = miso_oe_n ? ~last_bit : miso_o; // Undriven line
            last_bit = rx[i];
            sclk = 1'b1;
            #HALF;
            sclk = 1'b0;
        end
        #HALF;
        if (!hold) begin
            cs_n = 1'b1; // Held low only between chained bytes
            mosi = ~mosi;
        end
    endtask

    // A lone clock rise, sent on purpose mid-conversion
    task automatic pulse();
        cs_n = 1'b0;
        #HALF;
        sclk = 1'b1;
        #HALF;
        sclk = 1'b0;
        #HALF;
        cs_n = 1'b1;
    endtask
endmodule

// [verification/touch_adc_spi_command_port_test.sv]
`timescale 1ns/1ps
// ****
// Command port bench
// ****
module touch_adc_spi_command_port_test;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk, cs_n, mosi, miso_o, miso_oe_n;
    logic panel_touched = 1'b0;
    logic [11:0] adc_result = 12'hA5C;
    logic pen_touch_irq_n, adc_res_8bit, adc_powered, ref_ratiometric;
    logic [2:0] chan_sel;
    tascp_pkg::tascp_drv_s drv;
    logic pullup_90k, median_average_filter_bypass;
    logic conv_busy, result_valid, conv_invalid;
    logic [7:0] rx;
    int miscompares = 0;
    int cmp_count = 0;
    int busy_len = 0;
    int last_len = 0;

    always #25 ref_clk = ~ref_clk;

    // Length of the latest busy stretch
    always @(posedge ref_clk) begin
        busy_len <= conv_busy ? busy_len + 1 : 0;
        if (!conv_busy && busy_len != 0)
            last_len <= busy_len;
    end

    tascp_command_port u_tascp_command_port (.ref_clk(ref_clk),
        .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso_o(miso_o), .miso_oe_n(miso_oe_n),
        .panel_touched(panel_touched), .adc_result(adc_result),
        .pen_touch_irq_n(pen_touch_irq_n), .chan_sel(chan_sel),
        .adc_res_8bit(adc_res_8bit), .adc_powered(adc_powered),
        .ref_ratiometric(ref_ratiometric), .drv(drv),
        .pullup_90k(pullup_90k),
        .median_average_filter_bypass(median_average_filter_bypass),
        .conv_busy(conv_busy), .result_valid(result_valid),
        .conv_invalid(conv_invalid));
    tascp_host u_tascp_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso_o(miso_o), .miso_oe_n(miso_oe_n));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task automatic send(input logic [7:0] b);
        u_tascp_host.xfer(b, 1'b0, rx);
        tick(1);
    endtask
    task automatic wait_done();
        for (int n = 0; n < 2000 && conv_busy !== 1'b0; n++)
            tick(1);
        check(16'(conv_busy), 16'h0);
        tick(2);
    endtask
    task automatic check_len(input int exp);
        check(16'(last_len >= exp - 3 && last_len <= exp + 3), 16'h1);
    endtask

    // Scenarios
    task automatic t_reset();
        check(16'(pen_touch_irq_n), 16'h1);
        check(16'(pullup_90k), 16'h0);
        check(16'(median_average_filter_bypass), 16'h0);
        check(16'(miso_oe_n), 16'h1);
        check(16'(drv), 16'h1);
    endtask
    task automatic t_setup();
        send(8'hAC);
        check(16'(pullup_90k), 16'h1);
        check(16'(median_average_filter_bypass), 16'h1);
        check(16'(conv_busy), 16'h0);
        send(8'h20);
        check(16'(pullup_90k), 16'h1);
        check(16'(median_average_filter_bypass), 16'h1);
    endtask
    task automatic t_channels();
        logic [2:0] ch;
        logic rs;
        logic [3:0] de;
        for (int i = 0; i < 8; i++) begin
            ch = 3'(i);
            rs = !(ch inside {3'h1, 3'h4, 3'h5});
            de = ch == 3'h1 ? 4'h3 : ch == 3'h5 ? 4'hC :
                ch inside {3'h3, 3'h4} ? 4'h6 : 4'h0;
            if (ch != tascp_pkg::CH_SETUP) begin
                send({1'b1, ch, ch[0], rs, 2'b00});
                check(16'(conv_busy), 16'h1);
                check(16'(chan_sel), 16'(ch));
                check(16'(adc_res_8bit), 16'(ch[0]));
                check(16'(drv), 16'(de));
                check(16'(ref_ratiometric), 16'(!rs));
                check(16'(pen_touch_irq_n), 16'h0);
                check(16'(pullup_90k), 16'h1);
                wait_done();
                check(16'(result_valid), 16'h1);
                check(16'(pen_touch_irq_n), 16'h1);
                check(16'(adc_powered), 16'h0);
                check(16'(drv), 16'h1);
                check_len(ch[0] ? 45 : 130);
            end
        end
    endtask
    task automatic t_power();
        panel_touched = 1'b1;
        for (int pd = 0; pd < 4; pd++) begin
            send({1'b1, tascp_pkg::CH_X, 2'b00, 2'(pd)});
            wait_done();
            check(16'(adc_powered), 16'(pd % 2));
            check(16'(pen_touch_irq_n), 16'(pd % 2));
            check(16'(drv), pd % 2 ? 16'hC : 16'h1);
        end
        panel_touched = 1'b0;
        tick(4);
    endtask
    task automatic t_abort();
        send({1'b1, tascp_pkg::CH_Y, 4'h0});
        u_tascp_host.pulse();
        tick(6);
        check(16'(conv_busy), 16'h0);
        check(16'(conv_invalid), 16'h1);
        check(16'(pen_touch_irq_n), 16'h1);
    endtask
    task automatic t_new_cmd();
        u_tascp_host.xfer({1'b1, tascp_pkg::CH_Y, 4'h0}, 1'b1, rx);
        u_tascp_host.xfer({1'b1, tascp_pkg::CH_X, 4'h0}, 1'b0, rx);
        tick(1);
        check(16'(chan_sel), 16'(tascp_pkg::CH_X));
        check(16'(conv_busy), 16'h1);
        wait_done();
        check(16'(result_valid), 16'h1);
        check(16'(conv_invalid), 16'h0);
    endtask
    task automatic t_soft_early();
        send(8'hAD);
        check(16'(pullup_90k), 16'h0);
        check(16'(median_average_filter_bypass), 16'h0);
        send(8'hEC);
        wait_done();
        check_len(315);
        send(8'hA6);
        check(16'(rx), 16'(adc_result[11:5]));
        send(8'hEC);
        check(16'(rx), 16'h0);
        wait_done();
        u_tascp_host.xfer(8'h00, 1'b0, rx);
        tick(1);
        check(16'(rx), 16'(adc_result[11:4]));
        check(16'(conv_busy), 16'h0);
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(4);
        check(16'(median_average_filter_bypass), 16'h0);
    endtask

    task automatic print_verdict();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        tick(3);
        rst_n = 1'b1;
        tick(4);
        t_reset();
        t_setup();
        t_channels();
        t_power();
        t_abort();
        t_new_cmd();
        t_soft_early();
        print_verdict();
    end

    // Watchdog
    initial begin
        #1000000;
        miscompares++;
        print_verdict();
    end
endmodule
